/* File: tdm_connection_word_control.sv */
/*
  Connection word control for a four-stream time slot interchange, with
  the receive byte FIFO. Assumes serial inputs synchronous to i_core_clk,
  a bit clock at least eight core cycles long, frame pulse active low.
*/
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;

  assign o_in_ready = (wr_q - rd_q) != (PW+1)'(DEPTH);
  assign o_out_valid = wr_q != rd_q;
  assign o_out_data = mem[rd_q[PW-1:0]];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_q[PW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : word_fifo

module tdm_connection_word_control
  import tsi_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [WORD_W-1:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [WORD_W-1:0] o_rd_data,
  // serial streams
  input wire logic i_bit_clk,
  input wire logic i_frame_n,
  input wire logic [N_STREAMS-1:0] i_rx,
  output logic [N_STREAMS-1:0] o_tx,
  output logic [N_STREAMS-1:0] o_tx_oe,
  output logic o_cco
);
  localparam int EW = $bits(rx_entry_t);

  logic [WORD_W-1:0] cm [N_STREAMS*N_CHANNELS];
  logic [N_STREAMS*N_CHANNELS-1:0] cm_valid_q;
  logic [7:0] dmem [2*N_STREAMS*N_CHANNELS];
  logic [OFF_W-1:0] off_q [N_STREAMS];
  logic clk_prev_q;
  logic tick;
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] pos_d;
  logic page_q;
  logic boundary;
  logic [WORD_W-1:0] rd_data_q;

  // unwritten words read as zero: driver off, switching from 0/0
  function automatic logic [WORD_W-1:0] cm_word(
    input logic [STR_W-1:0] s, input logic [CH_W-1:0] c);
    logic [IDX_W-1:0] i;
    i = {s, c};
    cm_word = cm_valid_q[i] ? cm[i] : '0;
  endfunction : cm_word

  // bit clock edge and frame position
  assign tick = i_bit_clk & ~clk_prev_q;
  assign pos_d = !i_frame_n ? '0 : pos_q + 1'b1;
  assign boundary = tick & (pos_d[2:0] == '0);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_prev_q <= 1'b0;
      pos_q <= '0;
      page_q <= 1'b0;
    end else begin
      clk_prev_q <= i_bit_clk;
      if (tick) begin
        pos_q <= pos_d;
        if (!i_frame_n) page_q <= ~page_q;
      end
    end
  end

  // register writes
  always_ff @(posedge i_core_clk) begin
    if (i_wr_stb && !i_addr[IDX_W]) begin
      cm[i_addr[IDX_W-1:0]] <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cm_valid_q <= '0;
    end else if (i_wr_stb && !i_addr[IDX_W]) begin
      cm_valid_q[i_addr[IDX_W-1:0]] <= 1'b1;
    end
  end

  // offsets above four periods are clamped
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < N_STREAMS; k++) begin
        off_q[k] <= OFFSET_RESET[k*OFF_W +: OFF_W];
      end
    end else if (i_wr_stb && i_addr == OFFSET_ADDR) begin
      for (int k = 0; k < N_STREAMS; k++) begin
        off_q[k] <= (i_wr_data[k*OFF_W +: OFF_W] > OFF_MAX) ?
                    OFF_MAX : i_wr_data[k*OFF_W +: OFF_W];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_data_q <= '0;
    end else if (i_rd_stb) begin
      if (!i_addr[IDX_W]) begin
        rd_data_q <= cm_word(i_addr[8:7], i_addr[6:0]);
      end else if (i_addr == OFFSET_ADDR) begin
        rd_data_q <= {4'h0, off_q[3], off_q[2], off_q[1], off_q[0]};
      end else if (i_addr == STATUS_ADDR) begin
        rd_data_q <= {5'h00, page_q, pos_q};
      end else begin
        rd_data_q <= '0;
      end
    end else begin
      rd_data_q <= '0;
    end
  end
  assign o_rd_data = rd_data_q;

  // receive: one byte per stream per channel, queued for the data memory
  logic [7:0] rx_sr_q [N_STREAMS];
  logic [N_STREAMS-1:0] rx_pend_q;
  rx_entry_t rx_ent_q [N_STREAMS];
  logic [N_STREAMS-1:0] rx_bit;
  logic [STR_W-1:0] push_sel;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  rx_entry_t fifo_out;
  logic [N_STREAMS-1:0] tx_bit_q;
  logic [N_STREAMS-1:0] tx_next;

  always_comb begin
    push_sel = '0;
    for (int k = N_STREAMS-1; k >= 0; k--) begin
      if (rx_pend_q[k]) push_sel = STR_W'(k);
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < N_STREAMS; gs++) begin : g_rx
      logic [POS_W-1:0] rpos;
      logic [WORD_W-1:0] rword;
      // position being entered, so pin and loopback bits line up
      assign rpos = pos_d - POS_W'(off_q[gs]);
      assign rword = cm_word(STR_W'(gs), rpos[9:3]);
      assign rx_bit[gs] = rword[CHANNEL_LOOPBACK_BIT] ? tx_next[gs] : i_rx[gs];

      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          rx_sr_q[gs] <= '0;
          rx_pend_q[gs] <= 1'b0;
          rx_ent_q[gs] <= '0;
        end else begin
          if (fifo_in_ready && rx_pend_q[gs] && push_sel == STR_W'(gs)) begin
            rx_pend_q[gs] <= 1'b0;
          end
          if (tick) begin
            rx_sr_q[gs] <= {rx_sr_q[gs][6:0], rx_bit[gs]};
            if (rpos[2:0] == LAST_BIT) begin
              rx_pend_q[gs] <= 1'b1;
              rx_ent_q[gs] <= '{page_q, {STR_W'(gs), rpos[9:3]},
                                {rx_sr_q[gs][6:0], rx_bit[gs]}};
            end
          end
        end
      end
    end
  endgenerate

  word_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(|rx_pend_q),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rx_ent_q[push_sel]),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out)
  );

  always_ff @(posedge i_core_clk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      dmem[{fifo_out.page, fifo_out.idx}] <= fifo_out.data;
    end
  end

  // transmit fetch for the next channel; memory writes wait meanwhile
  fetch_state_t state_q;
  logic [STR_W-1:0] fk_q;
  logic [CH_W-1:0] tgt_q;
  logic [WORD_W-1:0] fw;
  logic fpg;
  logic [7:0] fbyte;
  logic [7:0] nxt_byte_q [N_STREAMS];
  logic [N_STREAMS-1:0] nxt_oe_q;
  logic [7:0] tx_byte_q [N_STREAMS];
  logic [N_STREAMS-1:0] oe_q;
  logic cco_q;

  assign fifo_out_ready = state_q == FETCH_IDLE;
  assign fw = cm_word(fk_q, tgt_q);
  // constant delay always reads last frame; variable reads this frame
  // when the source channel is below the target channel
  assign fpg = fw[DELAY_BIT] ? ~page_q :
               (fw[SRC_CH_HI:SRC_CH_LO] < tgt_q ? page_q : ~page_q);
  assign fbyte = fw[PROC_BIT] ? fw[BYTE_HI:0] :
                 dmem[{fpg, fw[SRC_STR_HI:SRC_STR_LO],
                       fw[SRC_CH_HI:SRC_CH_LO]}];

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= FETCH_IDLE;
      fk_q <= '0;
      tgt_q <= '0;
    end else begin
      case (state_q)
        FETCH_IDLE: begin
          if (boundary) begin
            state_q <= FETCH_RUN;
            fk_q <= '0;
            tgt_q <= pos_d[9:3] + 1'b1;
          end
        end
        FETCH_RUN: begin
          fk_q <= fk_q + 1'b1;
          if (fk_q == STR_W'(N_STREAMS-1)) state_q <= FETCH_IDLE;
        end
        default: state_q <= FETCH_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < N_STREAMS; k++) nxt_byte_q[k] <= '0;
      nxt_oe_q <= '0;
    end else if (state_q == FETCH_RUN) begin
      nxt_byte_q[fk_q] <= fbyte;
      nxt_oe_q[fk_q] <= fw[OE_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < N_STREAMS; k++) tx_byte_q[k] <= '0;
      oe_q <= '0;
      tx_bit_q <= '0;
    end else if (tick) begin
      tx_bit_q <= tx_next;
      if (boundary) tx_byte_q <= nxt_byte_q;
      if (boundary) oe_q <= nxt_oe_q;
    end
  end
  always_comb begin
    for (int k = 0; k < N_STREAMS; k++) begin
      tx_next[k] = boundary ? nxt_byte_q[k][BYTE_HI] :
                   tx_byte_q[k][LAST_BIT - pos_d[2:0]];
    end
  end
  assign o_tx = tx_bit_q;
  assign o_tx_oe = oe_q;

  // control pin: next channel's bits, stream 0 in the first bit slot
  logic [WORD_W-1:0] cco_word;
  assign cco_word = cm_word(pos_d[1:0], pos_d[9:3] + 1'b1);
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cco_q <= 1'b0;
    end else if (tick) begin
      cco_q <= (pos_d[2:0] < CCO_SLOTS) && cco_word[CCO_BIT];
    end
  end
  assign o_cco = cco_q;

  // checks
  a_proc_byte: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == FETCH_RUN && fw[PROC_BIT] |=>
    nxt_byte_q[$past(fk_q)] == $past(fw[BYTE_HI:0]))
    else $error("processor byte not staged");
  a_switch_src: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == FETCH_RUN && !fw[PROC_BIT] |->
    fbyte == dmem[{fpg, fw[8:0]}])
    else $error("switched byte from wrong source");
  a_const_page: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == FETCH_RUN && fw[DELAY_BIT] |-> fpg != page_q)
    else $error("constant delay read current frame");
  a_oe_slot: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    boundary |=> o_tx_oe == $past(nxt_oe_q) ##1 $stable(o_tx_oe))
    else $error("driver enable not taken at slot start");
  a_cco_early: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    tick && pos_d[2:0] >= CCO_SLOTS |=> !o_cco)
    else $error("control bit outside stream slots");
  a_loop_src: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    tick && g_rx[0].rword[CHANNEL_LOOPBACK_BIT] |=> rx_sr_q[0][0] == tx_bit_q[0])
    else $error("loopback took pin data");
  a_off_limit: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_wr_stb && i_addr == OFFSET_ADDR |=> off_q[0] <= OFF_MAX)
    else $error("offset beyond four periods");
  a_cm_store: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_wr_stb && !i_addr[IDX_W] ##1 i_rd_stb && $stable(i_addr) |=>
    o_rd_data == $past(i_wr_data, 2))
    else $error("connection word not stored");
  a_fetch_len: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(state_q == FETCH_RUN) |-> (state_q == FETCH_RUN) [*4] ##1
    state_q == FETCH_IDLE)
    else $error("fetch not four cycles");

  c_proc: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state_q == FETCH_RUN && fw[PROC_BIT]);
  c_loop: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    tick && rx_bit[0] != i_rx[0]);
  c_fifo_full: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !fifo_in_ready);
endmodule : tdm_connection_word_control

/* File: tsi_pkg.sv */
/*
  Shared constants and carrier types for the connection word control block.
  Assumes four serial streams of 128 eight-bit channels per frame.
*/
package tsi_pkg;
  localparam int N_STREAMS = 4;
  localparam int N_CHANNELS = 128;
  localparam int BITS_PER_CH = 8;
  localparam int WORD_W = 16;
  localparam int IDX_W = 9;
  localparam int POS_W = 10;
  localparam int CH_W = 7;
  localparam int STR_W = 2;
  localparam int OFF_W = 3;
  localparam int ADDR_W = 10;
  // connection word fields
  localparam int CHANNEL_LOOPBACK_BIT = 15;
  localparam int DELAY_BIT = 14;
  localparam int PROC_BIT = 13;
  localparam int CCO_BIT = 12;
  localparam int OE_BIT = 11;
  localparam int SRC_STR_HI = 8;
  localparam int SRC_STR_LO = 7;
  localparam int SRC_CH_HI = 6;
  localparam int SRC_CH_LO = 0;
  localparam int BYTE_HI = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] CCO_SLOTS = 3'h4;
  localparam logic [OFF_W-1:0] OFF_MAX = 3'h4;
  // register port map
  localparam logic [ADDR_W-1:0] OFFSET_ADDR = 10'h200;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 10'h201;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;

  typedef struct packed {
    logic page;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } rx_entry_t;

  typedef enum logic [0:0] {FETCH_IDLE, FETCH_RUN} fetch_state_t;
endpackage : tsi_pkg

/* File: stream_partner.sv */
/*
  Far-side stream model: free bit clock, frame pulse and input bytes.
  Assumes the block's core clock; one bit period is 16 core cycles.
*/
`timescale 1ns/1ps
module stream_partner (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // serial side
  output logic o_bit_clk,
  output logic o_frame_n,
  output logic [3:0] o_rx,
  output logic [9:0] o_pos
);
  logic [3:0] cnt_q;
  logic [9:0] np;
  assign np = o_pos + 10'h001;
  // fixed byte per stream and channel, so any page gives the same data
  function automatic logic pbit(input int s, input logic [9:0] p);
    logic [7:0] v;
    v = {s[1:0], p[8:3]} ^ 8'ha5;
    return v[3'h7 - p[2:0]];
  endfunction : pbit
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 4'h0;
      o_bit_clk <= 1'b0;
      o_frame_n <= 1'b1;
      o_rx <= 4'h0;
      o_pos <= 10'h3ff;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h7) begin
        o_bit_clk <= 1'b0;
      end
      if (cnt_q == 4'hf) begin
        o_bit_clk <= 1'b1;
        o_pos <= np;
        o_frame_n <= (np != 10'h000);
        for (int s = 0; s < 4; s++) begin
          o_rx[s] <= pbit(s, np);
        end
      end
    end
  end
endmodule : stream_partner

/* File: tb_tdm_connection_word_control.sv */
/*
  Self-checking bench: register port, then slot-by-slot serial output.
  Assumes stream_partner supplies bit clock, frame pulse and input data.
*/
`timescale 1ns/1ps
module tb_tdm_connection_word_control;
  logic clk;
  logic rst_n;
  logic [9:0] addr;
  logic [15:0] wdat;
  logic wr;
  logic rd;
  logic [15:0] rdat;
  logic bclk;
  logic frame_n;
  logic [3:0] rx;
  logic [3:0] tx;
  logic [3:0] oe;
  logic control_channel_out_bit;
  logic [9:0] pos;
  logic [3:0] txcap [1024];
  logic [3:0] oecap [1024];
  logic ccocap [1024];
  int error_cnt;
  int check_count;

  tdm_connection_word_control #(.FIFO_DEPTH(16)) i_tdm_connection_word_control (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wdat),
    .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdat), .i_bit_clk(bclk),
    .i_frame_n(frame_n), .i_rx(rx), .o_tx(tx), .o_tx_oe(oe), .o_cco(control_channel_out_bit)
  );
  stream_partner i_stream_partner (
    .i_core_clk(clk), .i_reset_n(rst_n), .o_bit_clk(bclk),
    .o_frame_n(frame_n), .o_rx(rx), .o_pos(pos)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // mid-bit sampling keeps clear of the launch edge
  always @(negedge bclk) begin
    txcap[pos] <= tx;
    oecap[pos] <= oe;
    ccocap[pos] <= control_channel_out_bit;
  end

  function automatic logic [7:0] pat(input logic [1:0] s, input logic [6:0] c);
    return {s, c[5:0]} ^ 8'ha5;
  endfunction : pat
  function automatic logic [7:0] got(input int s, input int c);
    logic [7:0] r;
    for (int b = 0; b < 8; b++) r[7-b] = txcap[c*8+b][s];
    return r;
  endfunction : got

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // write leaves the strobe up so a following access may be back to back
  task automatic wr_word(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdat <= d;
  endtask : wr_word
  task automatic rd_word(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask : rd_word
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
  endtask : idle
  task automatic wait_frame;
    int n;
    n = 0;
    while (frame_n !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    while (frame_n !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t no frame pulse", $time);
      final_report();
    end
  endtask : wait_frame

  task automatic t_regs;
    logic [15:0] d;
    rd_word(10'h114, d);
    check(d, 16'h0000);
    wr_word(10'h1ff, 16'h9987);
    rd_word(10'h1ff, d);
    check(d, 16'h9987);
    rd_word(10'h1fe, d);
    check(d, 16'h0000);
    wr_word(10'h3ff, 16'hffff);
    rd_word(10'h3ff, d);
    check(d, 16'h0000);
    wr_word(10'h200, 16'hffff);
    rd_word(10'h200, d);
    check(d, 16'h0924);
    wr_word(10'h200, 16'h0000);
    idle();
    $display("test regs done");
  endtask : t_regs

  task automatic t_serial;
    wr_word(10'h005, 16'h28a5);
    wr_word(10'h006, 16'h20ff);
    wr_word(10'h106, 16'h1000);
    wr_word(10'h08a, 16'h0803);
    wr_word(10'h08b, 16'h49e4);
    wr_word(10'h114, 16'ha83c);
    wr_word(10'h19e, 16'h4914);
    idle();
    repeat (4) wait_frame();
    check({8'h00, got(0, 5)}, 16'h00a5);
    check({8'h00, got(2, 20)}, 16'h003c);
    check({14'h0, oecap[40][0], oecap[47][0]}, 16'h0003);
    check({14'h0, oecap[48][0], oecap[56][0]}, 16'h0000);
    check({11'h0, ccocap[40], ccocap[41], ccocap[42], ccocap[43],
           ccocap[44]}, 16'h0004);
    check({8'h00, got(1, 10)}, {8'h00, pat(2'h0, 7'h03)});
    check({8'h00, got(1, 11)}, {8'h00, pat(2'h3, 7'h64)});
    check({8'h00, got(3, 30)}, 16'h003c);
    $display("test serial done");
  endtask : t_serial

  initial begin
    rst_n = 1'b0;
    addr = 10'h000;
    wdat = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_serial();
    final_report();
  end
endmodule : tb_tdm_connection_word_control
